//--- common/plcse_consts.svh
// constants of the logic-statement evaluator: field positions, codes, reset values, timing
`ifndef PLCSE_CONSTS_SVH
`define PLCSE_CONSTS_SVH

// statement word fields, lsb position of each byte
`define PLCSE_COND1_LSB 24
`define PLCSE_OP_LSB 16
`define PLCSE_COND2_LSB 8
`define PLCSE_ACT_LSB 0

// condition codes
`define PLCSE_C_FALSE 8'h00
`define PLCSE_C_TRUE 8'h01
`define PLCSE_C_IN1 8'h32
`define PLCSE_C_IN8 8'h39
`define PLCSE_C_VAR_A 8'h64
`define PLCSE_C_VAR_D 8'h67
`define PLCSE_C_TMR_A 8'h56
`define PLCSE_C_TMR_B 8'h57

// logic operator codes
`define PLCSE_OP_OR 8'h00
`define PLCSE_OP_AND 8'h01
`define PLCSE_OP_XOR 8'h02
`define PLCSE_OP_NOR 8'h03

// action codes
`define PLCSE_A_TBL_BIT1 8'h24
`define PLCSE_A_RELAY2 8'h25
`define PLCSE_A_TORQUE 8'h26
`define PLCSE_A_VAR_A 8'h28
`define PLCSE_A_VAR_D 8'h2B
`define PLCSE_A_TMR_A_ZERO 8'h32
`define PLCSE_A_TMR_A_LOAD 8'h33
`define PLCSE_A_TMR_B_ZERO 8'h34
`define PLCSE_A_TMR_B_LOAD 8'h35

// preset index that means zero speed
`define PLCSE_PRESET_ZERO 4'hF

// reset values
`define PLCSE_TABLE_RST 2'h0
`define PLCSE_VARS_RST 4'h0

// timing
`define PLCSE_CLK_HZ 40000000
`define PLCSE_SCAN_PERIOD_US 1000

`endif

//--- common/plcse_pkg.sv
// types of the logic-statement evaluator
`default_nettype none
package plcse_pkg;
  typedef enum logic [2:0] {
    PLCSE_IDLE   = 3'b001,
    PLCSE_EVAL   = 3'b010,
    PLCSE_COMMIT = 3'b100
  } plcse_state_t;
endpackage : plcse_pkg
`default_nettype wire

//--- rtl/plcse_evaluator.sv
// logic-statement evaluator: statement store, sequencer, actions, timers, index decodes
// Summary of operation
// - statement word: cond1 top byte, operator, cond2, action in lowest byte
// - action 36 drives table index bit 1; unprogrammed it reads cleared
// - action 37 drives relay 2, only when relay 2 source is the engine
// - action 38 selects torque, speed by default; torque ignored in V/Hz operation
// - actions 40 to 43 set or clear variables A to D
// - action 50 zeroes timer A when true, otherwise leaves it
// - action 51 loads timer A with its timeout count when true
// - actions 52 and 53 zero or load timer B when true
// - preset index 0 to 14 selects presets one to fifteen; 15 is zero speed
// - table index 0 to 3 selects and activates parameter tables one to four
// - fixed order; variables written earlier are seen later in the same pass
// - constant-true condition applies its action on every pass
// - with presets selected and no index bits, the first preset is used
// - each pass runs from the first slot through the last
// - timer condition true once counted to timeout uncleared
`include "plcse_consts.svh"
`default_nettype none
module plcse_evaluator #(
  parameter int NUM_STMT    = 16,
  parameter int TMR_W       = 16,
  parameter int SCAN_CYCLES = (`PLCSE_CLK_HZ / 1000000) * `PLCSE_SCAN_PERIOD_US
) (
  input  wire  logic                        clk,
  input  wire  logic                        rst,
  input  wire  logic                        stmt_we,
  input  wire  logic [$clog2(NUM_STMT)-1:0] stmt_addr,
  input  wire  logic [31:0]                 stmt_wdata,
  input  wire  logic [7:0]                  din_pins,
  input  wire  logic [TMR_W-1:0]            timer_a_timeout_count,
  input  wire  logic [TMR_W-1:0]            timer_b_timeout_count,
  input  wire  logic                        relay2_source_select,
  input  wire  logic                        vhz_mode,
  input  wire  logic                        table_bit0,
  input  wire  logic                        presets_active,
  input  wire  logic [3:0]                  preset_index,
  output var   logic [1:0]                  active_table_param,
  output var   logic [3:0]                  table_onehot,
  output var   logic                        relay2_out,
  output var   logic                        torque_mode,
  output var   logic [14:0]                 preset_speed_values,
  output var   logic                        zero_speed,
  output var   logic [3:0]                  vars_abcd,
  output var   logic                        timer_a_done,
  output var   logic                        timer_b_done,
  output var   logic                        pass_done
);

  localparam int IW = $clog2(NUM_STMT);
  localparam int SW = $clog2(SCAN_CYCLES);
  localparam logic [IW-1:0] LAST_IDX = IW'(NUM_STMT - 1);
  localparam logic [SW-1:0] SCAN_LAST = SW'(SCAN_CYCLES - 1);

  plcse_pkg::plcse_state_t state_q;
  logic [31:0]      stmt_mem [NUM_STMT];
  logic [IW-1:0]    idx_q;
  logic [SW-1:0]    scan_cnt_q;
  logic             scan_tick_q;
  logic [7:0]       din_m_q;
  logic [7:0]       din_s_q;
  logic [3:0]       vars_q;
  logic [TMR_W-1:0] tmr_a_q;
  logic [TMR_W-1:0] tmr_b_q;
  logic             tbl1_sh_q;
  logic             relay_sh_q;
  logic             torque_sh_q;

  // scan divider: one-cycle enable every scan period
  always_ff @(posedge clk) begin
    if (rst || scan_cnt_q == SCAN_LAST) begin
      scan_cnt_q <= '0;
    end else begin
      scan_cnt_q <= scan_cnt_q + 1'b1;
    end
    scan_tick_q <= !rst && scan_cnt_q == SCAN_LAST;
  end

  // input terminals come from pins, two flops before any use
  always_ff @(posedge clk) begin
    if (rst) begin
      din_m_q <= 8'h00;
      din_s_q <= 8'h00;
    end else begin
      din_m_q <= din_pins;
      din_s_q <= din_m_q;
    end
  end

  // statement store, written from the configuration side at any time
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_STMT; i++) begin
        stmt_mem[i] <= 32'h0000_0000;
      end
    end else if (stmt_we) begin
      stmt_mem[stmt_addr] <= stmt_wdata;
    end
  end

  // field split of the statement under evaluation
  wire logic [31:0] cur_word = stmt_mem[idx_q];
  wire logic [7:0]  cond1    = cur_word[`PLCSE_COND1_LSB +: 8];
  wire logic [7:0]  op_code  = cur_word[`PLCSE_OP_LSB +: 8];
  wire logic [7:0]  cond2    = cur_word[`PLCSE_COND2_LSB +: 8];
  wire logic [7:0]  act      = cur_word[`PLCSE_ACT_LSB +: 8];

  // timer conditions, true once counted up to the timeout
  wire logic tmr_a_hit = tmr_a_q >= timer_a_timeout_count;
  wire logic tmr_b_hit = tmr_b_q >= timer_b_timeout_count;

  // condition lookup; unknown codes read false so a typo cannot fire an action under OR or AND
  // every source is an argument: a continuous assignment only wakes on its operands,
  // so a variable written by the previous slot would otherwise be missed
  function automatic logic cond_val(input logic [7:0] code,
                                    input logic [7:0] din,
                                    input logic [3:0] vars,
                                    input logic       ta_hit,
                                    input logic       tb_hit);
    logic r;
    r = 1'b0;
    if (code == `PLCSE_C_TRUE) begin
      r = 1'b1;
    end else if (code >= `PLCSE_C_IN1 && code <= `PLCSE_C_IN8) begin
      r = din[3'(code - `PLCSE_C_IN1)];
    end else if (code >= `PLCSE_C_VAR_A && code <= `PLCSE_C_VAR_D) begin
      r = vars[2'(code - `PLCSE_C_VAR_A)]; // live variables
    end else if (code == `PLCSE_C_TMR_A) begin
      r = ta_hit;
    end else if (code == `PLCSE_C_TMR_B) begin
      r = tb_hit;
    end
    return r;
  endfunction : cond_val

  // operator combines the two conditions
  wire logic c1v = cond_val(cond1, din_s_q, vars_q, tmr_a_hit, tmr_b_hit);
  wire logic c2v = cond_val(cond2, din_s_q, vars_q, tmr_a_hit, tmr_b_hit);
  wire logic cval = (op_code == `PLCSE_OP_AND) ? (c1v & c2v) :
                    (op_code == `PLCSE_OP_XOR) ? (c1v ^ c2v) :
                    (op_code == `PLCSE_OP_NOR) ? !(c1v | c2v) : (c1v | c2v);
  wire logic evaluating = state_q == plcse_pkg::PLCSE_EVAL;
  wire logic committing = state_q == plcse_pkg::PLCSE_COMMIT;
  wire logic do_act     = evaluating;

  // sequencer: one statement per cycle, first slot to last
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= plcse_pkg::PLCSE_IDLE;
      idx_q   <= '0;
    end else begin
      unique case (state_q)
        plcse_pkg::PLCSE_IDLE: begin
          idx_q <= '0;
          if (scan_tick_q) begin
            state_q <= plcse_pkg::PLCSE_EVAL;
          end
        end
        plcse_pkg::PLCSE_EVAL: begin
          if (idx_q == LAST_IDX) begin
            state_q <= plcse_pkg::PLCSE_COMMIT;
          end else begin
            idx_q <= idx_q + 1'b1;
          end
        end
        plcse_pkg::PLCSE_COMMIT: begin
          state_q <= plcse_pkg::PLCSE_IDLE;
        end
      endcase
    end
  end

  // per-pass shadows start cleared so an unprogrammed action reads inactive
  always_ff @(posedge clk) begin
    if (rst || committing) begin
      tbl1_sh_q   <= 1'b0;
      relay_sh_q  <= 1'b0;
      torque_sh_q <= 1'b0;
    end else if (do_act) begin
      if (act == `PLCSE_A_TBL_BIT1) tbl1_sh_q <= cval;
      if (act == `PLCSE_A_RELAY2) relay_sh_q <= cval;
      if (act == `PLCSE_A_TORQUE) torque_sh_q <= cval;
    end
  end

  // logical variables persist between passes and update in order
  always_ff @(posedge clk) begin
    if (rst) begin
      vars_q <= `PLCSE_VARS_RST;
    end else if (do_act && act >= `PLCSE_A_VAR_A && act <= `PLCSE_A_VAR_D) begin
      vars_q[2'(act - `PLCSE_A_VAR_A)] <= cval;
    end
  end

  // timers: statement actions during the pass, one count at commit
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_a_q <= '0;
      tmr_b_q <= '0;
    end else if (do_act && cval) begin
      if (act == `PLCSE_A_TMR_A_ZERO) tmr_a_q <= '0;
      if (act == `PLCSE_A_TMR_A_LOAD) tmr_a_q <= timer_a_timeout_count;
      if (act == `PLCSE_A_TMR_B_ZERO) tmr_b_q <= '0;
      if (act == `PLCSE_A_TMR_B_LOAD) tmr_b_q <= timer_b_timeout_count;
    end else if (committing) begin
      // saturate at timeout so the count never wraps back to false
      if (!tmr_a_hit) tmr_a_q <= tmr_a_q + 1'b1;
      if (!tmr_b_hit) tmr_b_q <= tmr_b_q + 1'b1;
    end
  end

  // decodes of the two indexes, the preset decode gated by presets_active
  wire logic [1:0]  tbl_idx_d  = {tbl1_sh_q, table_bit0};
  wire logic [3:0]  tbl_oh_d   = 4'h1 << tbl_idx_d;
  wire logic [15:0] preset_dec = 16'h0001 << preset_index; // index 0 selects first preset
  wire logic [14:0] preset_d   = presets_active ? preset_dec[14:0] : 15'h0000;
  wire logic        zero_d     = presets_active && preset_index == `PLCSE_PRESET_ZERO;

  // pass results take effect together at commit
  always_ff @(posedge clk) begin
    if (rst) begin
      active_table_param <= `PLCSE_TABLE_RST;
      table_onehot       <= 4'h1;
      relay2_out         <= 1'b0;
      torque_mode        <= 1'b0;
    end else if (committing) begin
      active_table_param <= tbl_idx_d;
      table_onehot       <= tbl_oh_d;
      relay2_out         <= relay_sh_q && relay2_source_select;
      torque_mode        <= torque_sh_q && !vhz_mode;
    end
  end

  // preset decode and status flags, every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      preset_speed_values <= 15'h0000;
      zero_speed          <= 1'b0;
      timer_a_done        <= 1'b0;
      timer_b_done        <= 1'b0;
      pass_done           <= 1'b0;
    end else begin
      preset_speed_values <= preset_d;
      zero_speed          <= zero_d;
      timer_a_done        <= tmr_a_hit;
      timer_b_done        <= tmr_b_hit;
      pass_done           <= committing;
    end
  end

  assign vars_abcd = vars_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_commit;
    committing;
  endsequence

  AST_TBL_BIT1: assert property (s_commit |=> active_table_param[1] == $past(tbl1_sh_q))
    else $error("table bit 1 does not follow the pass result");
  AST_RELAY2_GATED: assert property (s_commit |=> relay2_out == ($past(relay_sh_q) && $past(relay2_source_select)))
    else $error("relay 2 not gated by its source selection");
  AST_NO_TORQUE_VHZ: assert property (s_commit ##0 vhz_mode |=> !torque_mode)
    else $error("torque selected in V/Hz operation");
  AST_VAR_UPDATE: assert property (do_act && act == `PLCSE_A_VAR_A |=> vars_q[0] == $past(cval))
    else $error("variable A did not take the condition");
  AST_TMR_A_ZERO: assert property (do_act && cval && act == `PLCSE_A_TMR_A_ZERO |=> tmr_a_q == '0)
    else $error("timer A not zeroed");
  AST_TMR_A_LOAD: assert property (do_act && cval && act == `PLCSE_A_TMR_A_LOAD
                                   |=> tmr_a_q == $past(timer_a_timeout_count))
    else $error("timer A not loaded");
  AST_TMR_B_ZERO: assert property (do_act && cval && act == `PLCSE_A_TMR_B_ZERO |=> tmr_b_q == '0)
    else $error("timer B not zeroed");
  AST_ZERO_SPEED: assert property (presets_active && preset_index == `PLCSE_PRESET_ZERO
                                   |=> zero_speed && preset_speed_values == 15'h0000)
    else $error("index 15 did not give zero speed");
  AST_TABLE_ONEHOT: assert property (s_commit |=> table_onehot == (4'h1 << active_table_param))
    else $error("table select decode wrong");
  AST_IDX_STEP: assert property (evaluating && idx_q != LAST_IDX |=> evaluating && idx_q == $past(idx_q) + 1'b1)
    else $error("statement slots not walked in order");
  AST_PASS_START: assert property (state_q == plcse_pkg::PLCSE_IDLE && scan_tick_q |=> evaluating && idx_q == '0)
    else $error("pass did not start at the first slot");
  AST_TMR_DONE: assert property (tmr_a_q >= timer_a_timeout_count ##1 $stable(timer_a_timeout_count)
                                 |-> timer_a_done)
    else $error("timer A done flag missing");

  // pass end, hold of untouched state, and the remaining decodes
  sequence s_last_slot;
    evaluating && idx_q == LAST_IDX;
  endsequence

  AST_LAST_COMMIT: assert property (s_last_slot |=> committing)
    else $error("last slot not followed by commit");
  AST_TMR_B_LOAD: assert property (do_act && cval && act == `PLCSE_A_TMR_B_LOAD
                                   |=> tmr_b_q == $past(timer_b_timeout_count))
    else $error("timer B not loaded");
  AST_VAR_HOLD: assert property (!(do_act && act >= `PLCSE_A_VAR_A && act <= `PLCSE_A_VAR_D) |=> $stable(vars_q))
    else $error("variables changed without their action");
  AST_TORQUE_SPEED: assert property (s_commit ##0 !vhz_mode |=> torque_mode == $past(torque_sh_q))
    else $error("torque select does not follow the pass result");
  AST_PRESET_ONEHOT: assert property (presets_active && preset_index != `PLCSE_PRESET_ZERO
                                      |=> preset_speed_values == (15'h0001 << $past(preset_index)) && !zero_speed)
    else $error("preset index decode wrong");
  AST_PRESET_OFF: assert property (!presets_active |=> preset_speed_values == 15'h0000 && !zero_speed)
    else $error("preset select active while presets deselected");
  AST_PASS_DONE: assert property (s_commit |=> pass_done)
    else $error("pass end pulse missing");

endmodule : plcse_evaluator
`default_nettype wire

//--- tb/plcse_din_model.sv
// digital input terminal model feeding the evaluator's input pins
`default_nettype none
module plcse_din_model (
  input  wire logic [7:0] level_req,
  output wire logic [7:0] din_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts settle a few ns after the request, never on a clock edge
  assign #3 din_pins = level_req;
endmodule : plcse_din_model
`default_nettype wire

//--- tb/plc_statement_evaluator_bench.sv
// self-checking bench: random programs against a pass-level model of the engine
`default_nettype none
module plc_statement_evaluator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NS = 16;
  localparam int SC = 40;
  logic        clk, rst, stmt_we, relay_sel, vhz, tb0, pre_act;
  logic        rel_o, trq_o, zs, ta_d, tb_d, pdone;
  logic [3:0]  stmt_addr, pre_idx, tbl_oh, vars;
  logic [31:0] stmt_wdata, rnd;
  logic [7:0]  din_req, din;
  logic [15:0] to_a, to_b;
  logic [1:0]  tbl;
  logic [14:0] pre_val;
  int          n_mismatch, checks_done, i;
  // bench mirror of the program and of the engine state
  logic [31:0] prog [NS];
  int          m_vars [4];
  int          m_ta, m_tb, m_tbl1, m_rel, m_trq;
  logic [7:0]  ctab [16] = '{8'h00, 8'h01, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37,
                             8'h38, 8'h39, 8'h64, 8'h65, 8'h66, 8'h67, 8'h56, 8'h57};
  logic [7:0]  atab [11] = '{8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h32, 8'h33, 8'h34, 8'h35};

  plcse_evaluator #(.NUM_STMT(NS), .TMR_W(16), .SCAN_CYCLES(SC)) dut_u (
    .clk(clk), .rst(rst), .stmt_we(stmt_we), .stmt_addr(stmt_addr), .stmt_wdata(stmt_wdata),
    .din_pins(din), .timer_a_timeout_count(to_a), .timer_b_timeout_count(to_b),
    .relay2_source_select(relay_sel), .vhz_mode(vhz), .table_bit0(tb0), .presets_active(pre_act),
    .preset_index(pre_idx), .active_table_param(tbl), .table_onehot(tbl_oh), .relay2_out(rel_o),
    .torque_mode(trq_o), .preset_speed_values(pre_val), .zero_speed(zs), .vars_abcd(vars),
    .timer_a_done(ta_d), .timer_b_done(tb_d), .pass_done(pdone));

  plcse_din_model din_u (.level_req(din_req), .din_pins(din));

  // free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // bounded wait for the end-of-pass pulse, then step past it
  task automatic wait_pass;
    int k;
    k = 0;
    while (pdone !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > 4 * SC) begin
        n_mismatch++;
        final_report();
      end
    end
    @(negedge clk);
  endtask : wait_pass

  function automatic int cond(input int c);
    if (c == 8'h01) return 1;
    if (c >= 8'h32 && c <= 8'h39) return int'(din_req[c - 8'h32]);
    if (c >= 8'h64 && c <= 8'h67) return m_vars[c - 8'h64];
    if (c == 8'h56) return int'(m_ta >= to_a);
    if (c == 8'h57) return int'(m_tb >= to_b);
    return 0;
  endfunction : cond

  // one pass, slot 0 first; earlier writes are seen by later slots
  task automatic model_pass;
    int a, b, r, act, j;
    m_tbl1 = 0;
    m_rel = 0;
    m_trq = 0;
    for (j = 0; j < NS; j++) begin
      a = cond(prog[j][31:24]);
      b = cond(prog[j][15:8]);
      case (prog[j][23:16])
        8'h01: r = a & b;
        8'h02: r = a ^ b;
        8'h03: r = int'(!(a | b));
        default: r = a | b;
      endcase
      act = prog[j][7:0];
      if (act == 8'h24) m_tbl1 = r;
      if (act == 8'h25) m_rel = r;
      if (act == 8'h26) m_trq = r;
      if (act >= 8'h28 && act <= 8'h2B) m_vars[act - 8'h28] = r;
      if (r != 0 && act == 8'h32) m_ta = 0;
      if (r != 0 && act == 8'h33) m_ta = to_a;
      if (r != 0 && act == 8'h34) m_tb = 0;
      if (r != 0 && act == 8'h35) m_tb = to_b;
    end
    // timers advance one count per pass, saturating at the timeout
    if (m_ta < to_a) m_ta++;
    if (m_tb < to_b) m_tb++;
  endtask : model_pass

  task automatic check_pass;
    model_pass();
    repeat (2) @(negedge clk);
    check(tbl, {m_tbl1[0], tb0});
    check(tbl_oh, 4'h1 << {m_tbl1[0], tb0});
    check(rel_o, m_rel[0] & relay_sel);
    check(trq_o, m_trq[0] & !vhz);
    check(vars, {m_vars[3][0], m_vars[2][0], m_vars[1][0], m_vars[0][0]});
    check(ta_d, m_ta >= to_a);
    check(tb_d, m_tb >= to_b);
  endtask : check_pass

  // rewrite four random slots and reshuffle the controls between passes
  task automatic shake;
    int j;
    for (j = 0; j < 4; j++) begin
      rnd = xs(rnd);
      stmt_addr = rnd[19:16];
      stmt_wdata = {ctab[rnd[3:0]], 8'(rnd[7:4] % 5), ctab[rnd[11:8]], atab[rnd[15:12] % 11]};
      prog[rnd[19:16]] = stmt_wdata;
      stmt_we = 1'b1;
      @(negedge clk);
    end
    stmt_we = 1'b0;
    rnd = xs(rnd);
    din_req = rnd[7:0];
    relay_sel = rnd[8];
    vhz = rnd[9] & rnd[10];
    tb0 = rnd[11];
    to_a = {14'h0000, rnd[13:12]};
    to_b = {14'h0000, rnd[15:14]};
  endtask : shake

  initial begin
    rst = 1'b1;
    stmt_we = 1'b0;
    stmt_addr = 4'h0;
    stmt_wdata = 32'h0000_0000;
    din_req = 8'h00;
    relay_sel = 1'b1;
    vhz = 1'b0;
    tb0 = 1'b0;
    pre_act = 1'b0;
    pre_idx = 4'h0;
    to_a = 16'h0003;
    to_b = 16'h0003;
    rnd = 32'h1ab2_16f8;
    n_mismatch = 0;
    checks_done = 0;
    m_ta = 0;
    m_tb = 0;
    for (i = 0; i < NS; i++) prog[i] = 32'h0000_0000;
    for (i = 0; i < 4; i++) m_vars[i] = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check(tbl_oh, 4'h1);
    check({tbl, rel_o, trq_o, vars, ta_d, tb_d, pdone}, 32'h0000_0000);
    // every preset index, then presets deselected
    pre_act = 1'b1;
    for (i = 0; i < 17; i++) begin
      pre_idx = i[3:0];
      if (i == 16) pre_act = 1'b0;
      repeat (2) @(negedge clk);
      check(pre_val, (i < 15) ? 15'h0001 << i : 15'h0000);
      check(zs, i == 15);
    end
    for (i = 0; i < 60; i++) begin
      wait_pass();
      check_pass();
      shake();
    end
    final_report();
  end
endmodule : plc_statement_evaluator_bench
`default_nettype wire
